// *** dmic_defs.svh ***
// Purpose: Offsets, fields, reset values and timing counts of the digital mic interface
// Assumes: Included by bare name from the design modules dmic_decim and dmic_if_top
// Notes:   Definitions only
`ifndef DMIC_DEFS_SVH
`define DMIC_DEFS_SVH

// Register offsets
`define DMIC_OFS_BIAS_CTRL   8'h19
`define DMIC_OFS_CONFIG      8'h6B
`define DMIC_OFS_STATUS      8'h6D

// Two-bit fields at D5-D4 of both registers
`define DMIC_FLD_HI          5
`define DMIC_FLD_LO          4

// Reset values
`define DMIC_RST_BIAS_CTRL   8'h00
`define DMIC_RST_CONFIG      8'h00
`define DMIC_RST_RDATA       8'h00

// Oversampling ratios and the log2 of twice each ratio
`define DMIC_OSR_128         8'h80
`define DMIC_OSR_64          8'h40
`define DMIC_OSR_32          8'h20
`define DMIC_SHIFT_128       8
`define DMIC_SHIFT_64        7
`define DMIC_SHIFT_32        6

// System clock cycles per ADC sample period
`define DMIC_FS_DIV          1024

`endif

// *** dmic_pkg.sv ***
// Purpose: Shared types of the digital mic interface
// Assumes: Encodings are written here as literals; dmic_defs.svh is not included
// Notes:   Types only
package dmic_pkg;

  typedef enum logic [1:0] {
    EDGE_OFF     = 2'b00,
    EDGE_RISE    = 2'b01,
    EDGE_FALL    = 2'b10,
    EDGE_BOTH    = 2'b11
  } edge_mode_t;

  typedef enum logic [1:0] {
    OSR_SEL_128  = 2'b00,
    OSR_SEL_64   = 2'b01,
    OSR_SEL_32   = 2'b10,
    OSR_SEL_RSVD = 2'b11
  } osr_sel_t;

  typedef enum logic [1:0] {
    CLK_OFF      = 2'b00,
    CLK_LOW      = 2'b01,
    CLK_HIGH     = 2'b11
  } clk_state_t;

  typedef struct packed {
    logic       valid;
    logic [9:0] data;
  } pcm_t;

endpackage : dmic_pkg

// *** dmic_decim.sv ***
// Purpose: Per-channel decimator turning a one-bit stream into signed samples
// Assumes: One bit offered per bit_valid_i pulse
// Notes:   Sample is twice the count of ones minus the ratio
`timescale 1ns/1ns
`include "dmic_defs.svh"
module dmic_decim
  import dmic_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Bit stream
  input  wire logic       enable_i,
  input  wire logic       bit_valid_i,
  input  wire logic       bit_i,
  input  wire logic [7:0] osr_i,
  // Sample out
  output pcm_t            pcm_o
);

  logic [7:0] bit_cnt;
  logic [7:0] ones;
  pcm_t       pcm;
  logic [7:0] next_bit_cnt;
  logic [7:0] next_ones;
  pcm_t       next_pcm;
  logic [7:0] ones_now;

  always_comb begin
    ones_now     = ones + {7'h00, bit_i};
    next_bit_cnt = bit_cnt;
    next_ones    = ones;
    next_pcm     = '{valid: 1'b0, data: pcm.data};
    if (!enable_i) begin
      next_bit_cnt = 8'h00;
      next_ones    = 8'h00;
    end else if (bit_valid_i) begin
      if (bit_cnt >= osr_i - 8'h01) begin
        next_pcm.valid = 1'b1;
        next_pcm.data  = {1'b0, ones_now, 1'b0} - {2'b00, osr_i};
        next_bit_cnt   = 8'h00;
        next_ones      = 8'h00;
      end else begin
        next_bit_cnt = bit_cnt + 8'h01;
        next_ones    = ones_now;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bit_cnt <= 8'h00;
      ones    <= 8'h00;
      pcm     <= '0;
    end else begin
      bit_cnt <= next_bit_cnt;
      ones    <= next_ones;
      pcm     <= next_pcm;
    end
  end

  assign pcm_o = pcm;

  AST_SAMPLE_AFTER_RATIO: assert property (@(posedge clk_i) disable iff (rst_i)
    pcm.valid |-> $past(bit_cnt) == $past(osr_i) - 8'h01 && $past(bit_valid_i))
    else $error("Sample emitted before a full ratio of bits");

  COV_SAMPLE: cover property (@(posedge clk_i) disable iff (rst_i) pcm.valid);

endmodule : dmic_decim

// *** dmic_if_top.sv ***
// Purpose: Digital microphone interface: clock out, edge capture, decimation
// Assumes: Registers reached by a plain byte-wide write/read port
// Notes:   Mic data pin is synchronised by two flip-flops before use
// Summary of operation
// - In mic mode the captured bits feed the decimators whose samples go out on left_pcm_o and right_pcm_o.
// - In mic mode an oversampling clock is produced for the microphone to send data by.
// - The clock runs at 128, 64 or 32 times the ADC sample rate as configured.
// - The oversampling clock is driven out on the mic clock pin while mic mode is on.
// - Data may be taken on rising edges, falling edges or both, for a stereo pair.
// - The left bit is taken from the mic data pin on each rising clock edge in the rising and both-edge modes.
// - The right bit is taken from the mic data pin on each falling clock edge in the falling and both-edge modes.
// - In mic mode neither ADC channel digitises analog inputs.
`timescale 1ns/1ns
`include "dmic_defs.svh"
module dmic_if_top
  import dmic_pkg::*;
#(
  parameter int FS_DIV = `DMIC_FS_DIV
)(
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  // Register port
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // Microphone pins
  output logic            mic_clock_pin_o,
  output logic            mic_clock_pin_oe_n_o,
  input  wire logic       mic_data_pin_i,
  // ADC side
  output logic            adc_analog_en_o,
  output logic            adc_left_pwr_o,
  output logic            adc_right_pwr_o,
  output pcm_t            left_pcm_o,
  output pcm_t            right_pcm_o
);

  // Registers
  logic [7:0] bias_ctrl;
  logic [7:0] config_reg;
  logic [7:0] rdata;
  logic [7:0] next_bias_ctrl;
  logic [7:0] next_config_reg;
  logic [7:0] next_rdata;

  // Clock generator
  clk_state_t state;
  clk_state_t next_state;
  logic [15:0] div_cnt;
  logic [15:0] next_div_cnt;
  logic        pin_clk;
  logic        next_pin_clk;
  logic        oe_n;
  logic        next_oe_n;
  logic        analog_en;
  logic        next_analog_en;
  logic        left_pwr;
  logic        next_left_pwr;
  logic        right_pwr;
  logic        next_right_pwr;

  // Sync and decode
  logic        data_meta;
  logic        data_sync;
  edge_mode_t  edge_mode;
  osr_sel_t    osr_sel;
  logic        dmic_en;
  logic [7:0]  osr;
  logic [15:0] half_cnt;
  logic        rise_now;
  logic        fall_now;
  logic        left_take;
  logic        right_take;

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      data_meta <= 1'b0;
      data_sync <= 1'b0;
    end else begin
      data_meta <= mic_data_pin_i;
      data_sync <= data_meta;
    end
  end

  assign edge_mode = edge_mode_t'(bias_ctrl[`DMIC_FLD_HI:`DMIC_FLD_LO]);
  assign osr_sel   = osr_sel_t'(config_reg[`DMIC_FLD_HI:`DMIC_FLD_LO]);
  assign dmic_en   = (edge_mode != EDGE_OFF);

  always_comb begin
    case (osr_sel)
      OSR_SEL_64: begin
        osr      = `DMIC_OSR_64;
        half_cnt = 16'(FS_DIV >> `DMIC_SHIFT_64);
      end
      OSR_SEL_32: begin
        osr      = `DMIC_OSR_32;
        half_cnt = 16'(FS_DIV >> `DMIC_SHIFT_32);
      end
      default: begin
        osr      = `DMIC_OSR_128;
        half_cnt = 16'(FS_DIV >> `DMIC_SHIFT_128);
      end
    endcase
  end

  // Register access
  always_comb begin
    next_bias_ctrl  = bias_ctrl;
    next_config_reg = config_reg;
    next_rdata      = rdata;
    if (reg_wr_i) begin
      case (reg_addr_i)
        `DMIC_OFS_BIAS_CTRL: next_bias_ctrl  = reg_wdata_i;
        `DMIC_OFS_CONFIG:    next_config_reg = reg_wdata_i;
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        `DMIC_OFS_BIAS_CTRL: next_rdata = bias_ctrl;
        `DMIC_OFS_CONFIG:    next_rdata = config_reg;
        `DMIC_OFS_STATUS:    next_rdata = {5'h00, state != CLK_OFF, right_pwr, left_pwr};
        default:             next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bias_ctrl  <= `DMIC_RST_BIAS_CTRL;
      config_reg <= `DMIC_RST_CONFIG;
      rdata      <= `DMIC_RST_RDATA;
    end else begin
      bias_ctrl  <= next_bias_ctrl;
      config_reg <= next_config_reg;
      rdata      <= next_rdata;
    end
  end

  // Oversampling clock
  always_comb begin
    next_state     = state;
    next_div_cnt   = div_cnt + 16'h0001;
    next_pin_clk   = pin_clk;
    next_oe_n      = 1'b0;
    rise_now       = 1'b0;
    fall_now       = 1'b0;
    next_analog_en = !dmic_en;
    next_left_pwr  = edge_mode[0];
    next_right_pwr = edge_mode[1];
    case (state)
      CLK_OFF: begin
        next_div_cnt = 16'h0000;
        next_oe_n    = !dmic_en;
        if (dmic_en) begin
          next_state = CLK_LOW;
        end
      end
      CLK_LOW: begin
        if (div_cnt >= half_cnt - 16'h0001) begin
          next_state   = CLK_HIGH;
          next_div_cnt = 16'h0000;
          next_pin_clk = 1'b1;
          rise_now     = 1'b1;
        end
      end
      CLK_HIGH: begin
        if (div_cnt >= half_cnt - 16'h0001) begin
          next_state   = CLK_LOW;
          next_div_cnt = 16'h0000;
          next_pin_clk = 1'b0;
          fall_now     = 1'b1;
        end
      end
      default: next_state = CLK_OFF;
    endcase
    if (!dmic_en) begin
      next_state   = CLK_OFF;
      next_div_cnt = 16'h0000;
      next_pin_clk = 1'b0;
      next_oe_n    = 1'b1;
      rise_now     = 1'b0;
      fall_now     = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state     <= CLK_OFF;
      div_cnt   <= 16'h0000;
      pin_clk   <= 1'b0;
      oe_n      <= 1'b1;
      analog_en <= 1'b1;
      left_pwr  <= 1'b0;
      right_pwr <= 1'b0;
    end else begin
      state     <= next_state;
      div_cnt   <= next_div_cnt;
      pin_clk   <= next_pin_clk;
      oe_n      <= next_oe_n;
      analog_en <= next_analog_en;
      left_pwr  <= next_left_pwr;
      right_pwr <= next_right_pwr;
    end
  end

  assign left_take  = rise_now && edge_mode[0];
  assign right_take = fall_now && edge_mode[1];

  // Decimation per channel
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      pcm_t pcm;
      dmic_decim u_decim (
        .clk_i       (mclk_i),
        .rst_i       (sys_rst_i),
        .enable_i    (dmic_en && edge_mode[ch]),
        .bit_valid_i ((ch == 0) ? left_take : right_take),
        .bit_i       (data_sync),
        .osr_i       (osr),
        .pcm_o       (pcm)
      );
    end
  endgenerate

  assign reg_rdata_o          = rdata;
  assign mic_clock_pin_o      = pin_clk;
  assign mic_clock_pin_oe_n_o = oe_n;
  assign adc_analog_en_o      = analog_en;
  assign adc_left_pwr_o       = left_pwr;
  assign adc_right_pwr_o      = right_pwr;
  assign left_pcm_o           = g_chan[0].pcm;
  assign right_pcm_o          = g_chan[1].pcm;

  // Helper: cycles since the last pin clock toggle
  logic [15:0] run_len;
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      run_len <= 16'h0000;
    end else if (pin_clk != next_pin_clk || state == CLK_OFF) begin
      run_len <= 16'h0000;
    end else begin
      run_len <= run_len + 16'h0001;
    end
  end

  AST_RELEASE_WHEN_OFF: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !dmic_en |=> mic_clock_pin_oe_n_o && !mic_clock_pin_o && !left_take && !right_take)
    else $error("Clock pin still driven with mic mode off");
  AST_DRIVE_WHEN_ON: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    dmic_en ##1 dmic_en |=> !mic_clock_pin_oe_n_o)
    else $error("Clock pin not driven in mic mode");
  AST_CLOCK_STARTS: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    $rose(dmic_en) ##0 dmic_en [*2] |-> ##[1:300] $rose(mic_clock_pin_o) or !dmic_en)
    else $error("Oversampling clock did not start");
  AST_HALF_PERIOD: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (pin_clk != next_pin_clk) && dmic_en && $stable(osr_sel) && $past(state) != CLK_OFF
    |-> run_len == half_cnt - 16'h0001)
    else $error("Clock half period does not match ratio");
  AST_LEFT_ON_RISE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    left_take |=> $rose(mic_clock_pin_o))
    else $error("Left bit taken off a rising edge");
  AST_RIGHT_ON_FALL: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    right_take |=> $fell(mic_clock_pin_o))
    else $error("Right bit taken off a falling edge");
  AST_EDGE_SELECT: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (left_take |-> !pin_clk) and (right_take |-> pin_clk) and
    (left_pcm_o.valid |-> adc_left_pwr_o) and (right_pcm_o.valid |-> adc_right_pwr_o))
    else $error("Bit taken on a disabled edge");
  AST_NO_ANALOG: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    dmic_en |=> !adc_analog_en_o)
    else $error("Analog path enabled in mic mode");
  AST_CFG_READBACK: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    reg_wr_i && reg_addr_i == `DMIC_OFS_CONFIG ##1
    reg_rd_i && !reg_wr_i && reg_addr_i == `DMIC_OFS_CONFIG
    |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("Config register read back wrong");

  COV_LEFT_TAKE: cover property (@(posedge mclk_i) disable iff (sys_rst_i) left_take);
  COV_BOTH: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
    edge_mode == EDGE_BOTH && right_take);
  COV_OSR32: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
    osr_sel == OSR_SEL_32 && rise_now);

endmodule : dmic_if_top

// *** mic_pair_model.sv ***
// Purpose: Stereo pair of digital mics sharing one data line
// Assumes: Clock pin idles low while stopped; data changes shortly after each mic clock edge
// Notes:   Left sends all ones, right sends a one on every fourth bit
`timescale 1ns/1ns
module mic_pair_model (
  // Clock and pins
  input  wire logic mclk_i,
  input  wire logic mic_clock_pin_i,
  output logic      mic_data_pin_o
);
  int   idle;
  int   rcnt;
  logic clk_q;
  initial begin
    mic_data_pin_o = 1'b0;
    idle = 99;
    rcnt = 0;
    clk_q = 1'b0;
  end
  always @(posedge mclk_i) begin
    #5;
    if (mic_clock_pin_i !== clk_q) begin
      idle = 0;
      if (mic_clock_pin_i === 1'b0) rcnt = rcnt + 1;
    end else if (idle < 99) begin
      idle = idle + 1;
    end
    clk_q = mic_clock_pin_i;
    // Released line changes every cycle
    if (idle > 40) mic_data_pin_o = ~mic_data_pin_o;
    else if (clk_q === 1'b1) mic_data_pin_o = (rcnt % 4 == 0);
    else mic_data_pin_o = 1'b1;
  end
endmodule : mic_pair_model

// *** digital_mic_pdm_interface_tb.sv ***
// Purpose: Self-checking bench of the digital mic interface
// Assumes: FS_DIV 1024, so the mic clock runs at 400 ns for ratio 128
// Notes:   Rows cover the three enabled edge modes and every ratio; first samples after enable are skipped
`timescale 1ns/1ns
module digital_mic_pdm_interface_tb;
  import dmic_pkg::*;
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] sel;
    logic [9:0] l_exp;
    logic [9:0] r_exp;
    logic [7:0] per;
  } row_t;
  localparam int FS = 1024;
  logic       mclk_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic       reg_wr_i = 1'b0;
  logic       reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic       mic_clock_pin_o;
  logic       mic_clock_pin_oe_n_o;
  logic       mic_data_pin_i;
  logic       adc_analog_en_o;
  logic       adc_left_pwr_o;
  logic       adc_right_pwr_o;
  pcm_t       left_pcm_o;
  pcm_t       right_pcm_o;
  wire logic  clk_wire = mic_clock_pin_oe_n_o ? 1'b0 : mic_clock_pin_o;
  int         fail_count = 0;
  int         n_compared = 0;
  int         l_cnt = 0;
  int         r_cnt = 0;
  int         l0;
  int         r0;
  int         n;
  logic [9:0] l_last;
  logic [9:0] r_last;
  row_t       rows [6] = '{
    '{2'h3, 2'h0, 10'h080, 10'h3C0, 8'h08}, '{2'h3, 2'h1, 10'h040, 10'h3E0, 8'h10},
    '{2'h3, 2'h2, 10'h020, 10'h3F0, 8'h20}, '{2'h3, 2'h3, 10'h080, 10'h3C0, 8'h08},
    '{2'h1, 2'h1, 10'h040, 10'h000, 8'h10}, '{2'h2, 2'h2, 10'h000, 10'h3F0, 8'h20}};

  dmic_if_top #(.FS_DIV(FS)) dmic_if_top_inst (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .mic_clock_pin_o(mic_clock_pin_o),
    .mic_clock_pin_oe_n_o(mic_clock_pin_oe_n_o), .mic_data_pin_i(mic_data_pin_i),
    .adc_analog_en_o(adc_analog_en_o), .adc_left_pwr_o(adc_left_pwr_o),
    .adc_right_pwr_o(adc_right_pwr_o), .left_pcm_o(left_pcm_o), .right_pcm_o(right_pcm_o));
  mic_pair_model mic_pair_model_inst (
    .mclk_i(mclk_i), .mic_clock_pin_i(clk_wire), .mic_data_pin_o(mic_data_pin_i));

  initial begin
    forever #25 mclk_i = ~mclk_i;
  end
  // Sample monitor
  always @(posedge mclk_i) begin
    if (left_pcm_o.valid === 1'b1) begin
      l_cnt <= l_cnt + 1;
      l_last <= left_pcm_o.data;
    end
    if (right_pcm_o.valid === 1'b1) begin
      r_cnt <= r_cnt + 1;
      r_last <= right_pcm_o.data;
    end
  end

  task automatic finish_test();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  task automatic chk_val(input logic [9:0] got, input logic [9:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_val
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask : reg_wr
  task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    @(negedge mclk_i);
    chk_val({2'h0, reg_rdata_o}, {2'h0, exp}, "register read");
  endtask : reg_chk
  task automatic wait_cnt(input bit left, input int target);
    for (int i = 0; i < 5000; i++) begin
      @(posedge mclk_i);
      if ((left ? l_cnt : r_cnt) >= target) return;
    end
    chk_val(10'h001, 10'h000, "sample timeout");
    finish_test();
  endtask : wait_cnt
  task automatic meas_per(output int per);
    int   first;
    logic prev;
    first = -1;
    prev = 1'b1;
    per = 0;
    for (int i = 0; i < 300; i++) begin
      @(negedge mclk_i);
      if (mic_clock_pin_o === 1'b1 && prev === 1'b0) begin
        if (first >= 0) begin
          per = i - first;
          return;
        end
        first = i;
      end
      prev = mic_clock_pin_o;
    end
  endtask : meas_per
  task automatic chk_idle();
    chk_val({9'h0, mic_clock_pin_o}, 10'h000, "clock pin level");
    chk_val({9'h0, mic_clock_pin_oe_n_o}, 10'h001, "clock pin enable");
    chk_val({9'h0, adc_analog_en_o}, 10'h001, "analog enable");
    chk_val({8'h0, adc_right_pwr_o, adc_left_pwr_o}, 10'h000, "channel power");
  endtask : chk_idle

  initial begin
    repeat (6) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(negedge mclk_i);
    chk_idle();
    reg_chk(8'h19, 8'h00);
    reg_chk(8'h6B, 8'h00);
    reg_chk(8'h6D, 8'h00);
    reg_chk(8'h42, 8'h00);
    reg_wr(8'h6D, 8'hFF);
    reg_chk(8'h6D, 8'h00);
    foreach (rows[k]) begin
      reg_wr(8'h19, 8'h00);
      reg_wr(8'h6B, {2'b00, rows[k].sel, 4'h0});
      reg_wr(8'h19, {2'b00, rows[k].mode, 4'h0});
      meas_per(n);
      chk_val(10'(n), {2'h0, rows[k].per}, "clock period");
      chk_val({9'h0, mic_clock_pin_oe_n_o}, 10'h000, "clock pin enable");
      chk_val({9'h0, adc_analog_en_o}, 10'h000, "analog enable");
      chk_val({8'h0, adc_right_pwr_o, adc_left_pwr_o}, {8'h0, rows[k].mode}, "power");
      reg_chk(8'h6D, {5'h0, 1'b1, rows[k].mode});
      l0 = l_cnt;
      r0 = r_cnt;
      if (rows[k].mode[0]) wait_cnt(1'b1, l0 + 3);
      if (rows[k].mode[1]) wait_cnt(1'b0, r0 + 3);
      if (rows[k].mode[0]) chk_val(l_last, rows[k].l_exp, "left sample");
      else chk_val(10'(l_cnt - l0), 10'h000, "left samples");
      if (rows[k].mode[1]) chk_val(r_last, rows[k].r_exp, "right sample");
      else chk_val(10'(r_cnt - r0), 10'h000, "right samples");
    end
    // Read in the cycle of a write, then read back at once
    @(posedge mclk_i);
    reg_addr_i <= 8'h6B;
    reg_wdata_i <= 8'h1F;
    reg_wr_i <= 1'b1;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
    @(negedge mclk_i);
    chk_val({2'h0, reg_rdata_o}, 10'h020, "read during write");
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    @(negedge mclk_i);
    chk_val({2'h0, reg_rdata_o}, 10'h01F, "read after write");
    reg_chk(8'h6B, 8'h1F);
    // Mode off in mid-run
    reg_wr(8'h19, 8'h00);
    repeat (2) @(negedge mclk_i);
    chk_idle();
    l0 = l_cnt;
    r0 = r_cnt;
    repeat (1100) @(posedge mclk_i);
    chk_val(10'(l_cnt - l0 + r_cnt - r0), 10'h000, "samples while off");
    // Reset in mid-run
    reg_wr(8'h19, 8'h30);
    repeat (300) @(posedge mclk_i);
    sys_rst_i <= 1'b1;
    @(negedge mclk_i);
    chk_idle();
    chk_val(left_pcm_o.data | right_pcm_o.data, 10'h000, "pcm in reset");
    @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    reg_chk(8'h19, 8'h00);
    reg_chk(8'h6B, 8'h00);
    finish_test();
  end
endmodule : digital_mic_pdm_interface_tb
